// ---- irq_source_model.sv ----
/* Interrupt-raising peripheral: its flag rises a set lag after a request.
   Assumes the bench clears the flag once the wake has been seen. */
`timescale 1ns/10ps
module irq_source_model (
   input wire logic clock_i, rst_i, raise_i, clear_i,
   input wire logic [3:0] lag_i,
   output logic flag_o
);
   logic [3:0] cnt_q;
   always_ff @(posedge clock_i) begin
      if (rst_i || clear_i) begin
         cnt_q <= 4'h0;
         flag_o <= 1'b0;
      end else begin
         cnt_q <= raise_i ? lag_i : cnt_q - {3'h0, cnt_q != 4'h0};
         if (cnt_q == 4'h1) flag_o <= 1'b1;
      end
   end
endmodule : irq_source_model

// ---- sleep_wakeup_controller.sv ----
/*
 * Sleep and wake-up controller: enters power-down on the sleep instruction,
 * updates the status flags and watchdog, waits for a wake source and sequences
 * the return to execution in line or through the interrupt vector.
 * Assumes the core pulses sleep_exec_i for one cycle per sleep instruction and
 * that peripheral wake requests come only from units that can run unclocked.
 */
//
// Contract
// [R01] Sleep instruction enters power-down.
// [R02] Entry clears watchdog, clears powerdown, sets timeout, stops oscillator.
// [R03] I/O pins hold their drive state asleep.
// [R04] Wake on reset pin, watchdog, or interrupt.
// [R05] Reset pin resets; other sources resume execution.
// [R06] Powerdown flag set at power-up, cleared by sleep.
// [R07] Watchdog wake clears timeout flag.
// [R08] Only clock-independent peripherals may wake.
// [R09] Clock-dependent peripherals raise nothing while asleep.
// [R10] Sleep prefetches instruction at next address.
// [R11] Enabled source wakes regardless of global enable.
// [R12] Run prefetched instruction, then in line or vector.
// [R13] Pending enabled interrupt turns sleep into no-op.
// [R14] Interrupt during sleep: complete entry, wake immediately.
// [R15] Crystal wake waits 1024 oscillator periods (code waits OST_PERIODS + 1, i.e. 1025).
// [R16] Vectored wake inserts two dummy cycles.
`timescale 1ns/10ps
module sleep_wakeup_controller
   import sleep_wakeup_pkg::*;
#(
   parameter int unsigned OSC_DIV = OSC_DIV_DEFAULT,
   parameter int unsigned OST_PERIODS = OSC_START_PERIODS,
   parameter int unsigned IO_WIDTH = 8
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic sleep_exec_i,
   input wire logic master_clear_pin_i,
   input wire logic watchdog_enable_i,
   input wire logic watchdog_timeout_i,
   input wire logic external_irq_flag_i,
   input wire logic external_irq_enable_i,
   input wire logic port_b_change_flag_i,
   input wire logic port_b_change_enable_i,
   input wire logic [NUM_PERIPH-1:0] periph_flag_i,
   input wire logic [NUM_PERIPH-1:0] periph_enable_i,
   input wire logic periph_group_enable_i,
   input wire logic [NUM_PERIPH-1:0] periph_clockless_i,
   input wire logic global_irq_enable_i,
   input wire logic crystal_mode_i,
   input wire logic [IO_WIDTH-1:0] io_out_i,
   input wire logic [IO_WIDTH-1:0] io_oe_i,
   output logic powerdown_flag_o,
   output logic timeout_flag_o,
   output logic watchdog_clear_o,
   output logic osc_enable_o,
   output logic asleep_o,
   output logic device_reset_o,
   output logic hold_fetch_o,
   output logic exec_prefetched_o,
   output logic dummy_cycle_o,
   output logic vector_load_o,
   output logic [12:0] vector_addr_o,
   output logic [IO_WIDTH-1:0] io_out_o,
   output logic [IO_WIDTH-1:0] io_oe_o
);

   localparam int unsigned OST_W = $clog2(OST_PERIODS + 1);
   localparam int unsigned DIV_W = $clog2(OSC_DIV + 1);

   initial begin
      if (OSC_DIV < 1 || OST_PERIODS < 1 || IO_WIDTH < 1) begin
         $error("sleep_wakeup_controller: parameters must be at least one");
      end
   end

   wake_state_t state_q, state_d;
   logic powerdown_q;
   logic timeout_q;
   logic wdt_clear_q;
   logic osc_en_q;
   logic asleep_q;
   logic hold_q;
   logic dev_reset_q;
   logic exec_pref_q;
   logic dummy_q;
   logic vec_load_q;
   logic vectored_q;
   logic [IO_WIDTH-1:0] io_out_q;
   logic [IO_WIDTH-1:0] io_oe_q;
   logic [OST_W-1:0] ost_cnt_q;
   logic [DIV_W-1:0] div_cnt_q;
   logic [1:0] dummy_cnt_q;

   // Peripherals that need the core clock are masked out while asleep.
   wire logic asleep = (state_q == ST_SLEEP);
   wire logic [NUM_PERIPH-1:0] periph_ok =
      periph_flag_i & periph_enable_i & (asleep ? periph_clockless_i : {NUM_PERIPH{1'b1}}); // [R08] [R09]
   wire logic irq_pending = (external_irq_flag_i & external_irq_enable_i)
      | (port_b_change_flag_i & port_b_change_enable_i)
      | (periph_group_enable_i & (|periph_ok)); // [R11]
   wire logic sleep_take = (state_q == ST_RUN) && sleep_exec_i;
   wire logic sleep_enter = sleep_take && !irq_pending; // [R13]
   wire logic wdt_wake = asleep && watchdog_enable_i && watchdog_timeout_i; // [R04]
   wire logic irq_wake = asleep && irq_pending; // [R14]
   wire logic wake = wdt_wake || irq_wake;
   wire logic osc_tick = (div_cnt_q == DIV_W'(OSC_DIV - 1));
   wire logic ost_done = (ost_cnt_q == OST_W'(OST_PERIODS)) && osc_tick;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (sleep_enter) begin
               state_d = ST_SLEEP; // [R01]
            end
         end
         ST_SLEEP: begin
            if (wake) begin
               state_d = crystal_mode_i ? ST_OSC_WAIT : ST_PREFETCH; // [R15]
            end
         end
         ST_OSC_WAIT: begin
            if (ost_done) begin
               state_d = ST_PREFETCH;
            end
         end
         ST_PREFETCH: begin
            state_d = vectored_q ? ST_DUMMY : ST_RUN; // [R12]
         end
         ST_DUMMY: begin
            if (dummy_cnt_q == 2'(DUMMY_CYCLES - 1)) begin
               state_d = ST_RUN; // [R16]
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   // Master clear synchronously resets state, flags and counters; pin and pulse output registers reset on rst_i only.
   wire logic full_reset = rst_i || master_clear_pin_i; // [R05]

   always_ff @(posedge clock_i) begin
      if (full_reset) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clock_i) begin
      if (full_reset) begin
         powerdown_q <= POWERDOWN_FLAG_RESET; // [R06]
         timeout_q <= TIMEOUT_FLAG_RESET;
      end else if (sleep_enter) begin
         powerdown_q <= 1'b0; // [R02] [R06]
         timeout_q <= 1'b1; // [R02]
      end else if (wdt_wake) begin
         timeout_q <= 1'b0; // [R07]
      end
   end

   always_ff @(posedge clock_i) begin
      if (full_reset) begin
         wdt_clear_q <= 1'b0;
         osc_en_q <= 1'b1;
         asleep_q <= 1'b0;
         hold_q <= 1'b0;
         vectored_q <= 1'b0;
      end else begin
         wdt_clear_q <= sleep_enter; // [R02]
         osc_en_q <= !(state_d == ST_SLEEP || state_d == ST_OSC_WAIT); // [R02]
         asleep_q <= (state_d == ST_SLEEP || state_d == ST_OSC_WAIT);
         hold_q <= (state_d == ST_SLEEP || state_d == ST_OSC_WAIT); // [R15]
         if (wake) begin
            vectored_q <= irq_wake && !wdt_wake && global_irq_enable_i; // [R12]
         end
      end
   end

   // Pins are frozen at entry and released once execution resumes.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         io_out_q <= '0;
         io_oe_q <= '0;
      end else if (state_d == ST_RUN || state_d == ST_PREFETCH || state_d == ST_DUMMY) begin
         io_out_q <= io_out_i;
         io_oe_q <= io_oe_i;
      end // [R03]
   end

   // Oscillator start-up counter on a divided enable.
   always_ff @(posedge clock_i) begin
      if (full_reset || state_q != ST_OSC_WAIT) begin
         div_cnt_q <= '0;
         ost_cnt_q <= '0;
      end else if (osc_tick) begin
         div_cnt_q <= '0;
         if (ost_cnt_q != OST_W'(OST_PERIODS)) begin
            ost_cnt_q <= ost_cnt_q + OST_W'(1); // [R15]
         end
      end else begin
         div_cnt_q <= div_cnt_q + DIV_W'(1);
      end
   end

   always_ff @(posedge clock_i) begin
      if (full_reset || state_q != ST_DUMMY) begin
         dummy_cnt_q <= '0;
      end else begin
         dummy_cnt_q <= dummy_cnt_q + 2'd1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         dev_reset_q <= 1'b1;
         exec_pref_q <= 1'b0;
         dummy_q <= 1'b0;
         vec_load_q <= 1'b0;
      end else begin
         dev_reset_q <= master_clear_pin_i; // [R05]
         exec_pref_q <= (state_d == ST_PREFETCH); // [R10] [R12]
         dummy_q <= (state_d == ST_DUMMY); // [R16]
         vec_load_q <= (state_q == ST_DUMMY) && (state_d == ST_RUN); // [R12]
      end
   end

   assign powerdown_flag_o = powerdown_q;
   assign timeout_flag_o = timeout_q;
   assign watchdog_clear_o = wdt_clear_q;
   assign osc_enable_o = osc_en_q;
   assign asleep_o = asleep_q;
   assign device_reset_o = dev_reset_q;
   assign hold_fetch_o = hold_q;
   assign exec_prefetched_o = exec_pref_q;
   assign dummy_cycle_o = dummy_q;
   assign vector_load_o = vec_load_q;
   assign vector_addr_o = IRQ_VECTOR;
   assign io_out_o = io_out_q;
   assign io_oe_o = io_oe_q;

endmodule : sleep_wakeup_controller

// ---- sleep_wakeup_controller_properties.sv ----
/* Port checker for the sleep and wake-up controller.
   Assumes one clock, small start-up figures and a bind by name. */
`timescale 1ns/10ps
module sleep_wakeup_controller_properties
   import sleep_wakeup_pkg::*;
#(parameter int unsigned IO_WIDTH = 8) (
   input wire logic clock_i, rst_i, sleep_exec_i, master_clear_pin_i, watchdog_enable_i, watchdog_timeout_i,
   input wire logic external_irq_flag_i, external_irq_enable_i, port_b_change_flag_i, port_b_change_enable_i,
   input wire logic [NUM_PERIPH-1:0] periph_flag_i, periph_enable_i, periph_clockless_i,
   input wire logic periph_group_enable_i, global_irq_enable_i, crystal_mode_i, powerdown_flag_o,
   input wire logic timeout_flag_o, watchdog_clear_o, osc_enable_o, asleep_o, device_reset_o,
   input wire logic exec_prefetched_o, dummy_cycle_o, vector_load_o,
   input wire logic [12:0] vector_addr_o,
   input wire logic [IO_WIDTH-1:0] io_out_o, io_oe_o
);
   wire logic [NUM_PERIPH-1:0] pe = periph_flag_i & periph_enable_i & {NUM_PERIPH{periph_group_enable_i}};
   wire logic xi = (external_irq_flag_i & external_irq_enable_i) | (port_b_change_flag_i & port_b_change_enable_i);
   wire logic irq_run = xi | (|pe);
   wire logic irq_nap = xi | (|(pe & periph_clockless_i));
   wire logic run = osc_enable_o & ~exec_prefetched_o & ~dummy_cycle_o;
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i || master_clear_pin_i);
   a_entry_flags: assert property (run && sleep_exec_i && !irq_run |=>
      !powerdown_flag_o && timeout_flag_o && watchdog_clear_o && asleep_o) else $error("bad entry");
   a_sleep_noop: assert property (run && sleep_exec_i && irq_run |=>
      powerdown_flag_o == $past(powerdown_flag_o) && !watchdog_clear_o && !asleep_o) else $error("bad noop");
   a_pins_hold: assert property (asleep_o && $past(asleep_o) |-> $stable(io_out_o) && $stable(io_oe_o))
      else $error("pins moved");
   a_irq_wake: assert property (asleep_o && irq_nap && !crystal_mode_i |=> exec_prefetched_o)
      else $error("no wake");
   a_stay_asleep: assert property (asleep_o && !irq_nap && !watchdog_timeout_i |=> asleep_o)
      else $error("stray wake");
   a_crystal_hold: assert property (asleep_o && $rose(irq_nap) && crystal_mode_i |=> !osc_enable_o [*2])
      else $error("early start");
   a_wdt_wake: assert property (asleep_o && watchdog_timeout_i && watchdog_enable_i |=> !timeout_flag_o)
      else $error("timeout flag");
   a_vector_seq: assert property (exec_prefetched_o && timeout_flag_o && $past(global_irq_enable_i) |=>
      dummy_cycle_o [*2] ##1 vector_load_o && vector_addr_o == IRQ_VECTOR) else $error("bad vector");
   a_inline_run: assert property (exec_prefetched_o && !$past(global_irq_enable_i) |=>
      !(dummy_cycle_o || vector_load_o) [*3]) else $error("bad inline");
   a_pin_reset: assert property (@(posedge clock_i) disable iff (rst_i) master_clear_pin_i |=>
      device_reset_o && powerdown_flag_o && !asleep_o) else $error("bad pin reset");
   c_vector: cover property (vector_load_o);
   c_crystal: cover property (exec_prefetched_o && crystal_mode_i);
   c_noop: cover property (run && sleep_exec_i && irq_run);
endmodule : sleep_wakeup_controller_properties
bind sleep_wakeup_controller sleep_wakeup_controller_properties #(.IO_WIDTH(IO_WIDTH)) props_u (.*);

// ---- sleep_wakeup_controller_tb.sv ----
/* Self-checking bench for the sleep and wake-up controller.
   Assumes the checker and the interrupt source model are compiled first. */
`timescale 1ns/10ps
module sleep_wakeup_controller_tb;
   import sleep_wakeup_pkg::*;
   logic clock_i = 0, rst_i = 1, sleep_exec_i = 0, master_clear_pin_i = 0, watchdog_enable_i = 0, raise = 0;
   logic watchdog_timeout_i = 0, external_irq_enable_i = 1, port_b_change_flag_i = 0, port_b_change_enable_i = 1;
   logic periph_group_enable_i = 1, global_irq_enable_i = 0, crystal_mode_i = 0, clear = 0, external_irq_flag_i;
   logic [NUM_PERIPH-1:0] periph_flag_i = 0, periph_enable_i = '1, periph_clockless_i = 9'h001;
   logic [7:0] io_out_i = 8'h5a, io_oe_i = 8'h0f, io_out_o, io_oe_o;
   logic powerdown_flag_o, timeout_flag_o, watchdog_clear_o, osc_enable_o, asleep_o, device_reset_o;
   logic exec_prefetched_o, dummy_cycle_o, vector_load_o, hold_fetch_o;
   logic [12:0] vector_addr_o;
   int mismatches = 0, checks_done = 0, cycles = 0;
   always #2.5 clock_i = ~clock_i;
   sleep_wakeup_controller #(.OSC_DIV(1), .OST_PERIODS(4)) dut_u (.*);
   irq_source_model src_u (.clock_i, .rst_i, .raise_i(raise), .clear_i(clear), .lag_i(4'h3),
      .flag_o(external_irq_flag_i));
   task automatic chk(input logic [23:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : step
   task automatic nap;
      @(posedge clock_i) sleep_exec_i <= 1;
      @(posedge clock_i) sleep_exec_i <= 0;
      #1;
      if (port_b_change_flag_i) chk({watchdog_clear_o, powerdown_flag_o, asleep_o}, 3'h2);
      else chk({hold_fetch_o, watchdog_clear_o, powerdown_flag_o, timeout_flag_o, asleep_o}, 5'h1b);
   endtask : nap
   task automatic wake_count(output int n);
      n = 0;
      do begin
         step(1);
         n++;
      end while (exec_prefetched_o !== 1'b1 && n < 40);
   endtask : wake_count
   task automatic s_noop;
      @(posedge clock_i) port_b_change_flag_i <= 1;
      nap();
      @(posedge clock_i) port_b_change_flag_i <= 0;
   endtask : s_noop
   task automatic s_sources;
      int n;
      for (int i = 0; i < 2; i++) begin
         @(posedge clock_i) crystal_mode_i <= i[0];
         nap();
         @(posedge clock_i) periph_flag_i <= 9'h002;
         {io_oe_i, io_out_i} <= 16'hf0a5;
         step(4);
         chk({asleep_o, io_oe_o, io_out_o}, 17'h1_0f5a);
         @(posedge clock_i) periph_flag_i <= 9'h003;
         wake_count(n);
         chk(n, i ? 6 : 1);
         @(posedge clock_i) periph_flag_i <= 0;
         {io_oe_i, io_out_i} <= 16'h0f5a;
      end
      @(posedge clock_i) crystal_mode_i <= 0;
   endtask : s_sources
   task automatic s_irq;
      int n;
      logic [5:0] seq;
      for (int g = 0; g < 2; g++) begin
         @(posedge clock_i) external_irq_enable_i <= 0;
         global_irq_enable_i <= g[0];
         nap();
         @(posedge clock_i) raise <= 1;
         @(posedge clock_i) raise <= 0;
         step(6);
         chk(asleep_o, 1);
         @(posedge clock_i) external_irq_enable_i <= 1;
         wake_count(n);
         for (int k = 0; k < 3; k++) begin
            step(1);
            seq = {seq[3:0], dummy_cycle_o, vector_load_o};
         end
         chk({seq, vector_addr_o}, {g ? 6'h29 : 6'h00, IRQ_VECTOR});
         @(posedge clock_i) clear <= 1;
         @(posedge clock_i) clear <= 0;
      end
      @(posedge clock_i) global_irq_enable_i <= 0;
   endtask : s_irq
   task automatic s_watchdog;
      nap();
      for (int e = 0; e < 2; e++) begin
         @(posedge clock_i) watchdog_enable_i <= e[0];
         watchdog_timeout_i <= 1;
         @(posedge clock_i) watchdog_timeout_i <= 0;
         step(2);
         chk({asleep_o, timeout_flag_o}, e ? 2'h0 : 2'h3);
      end
   endtask : s_watchdog
   task automatic s_pin_reset;
      nap();
      @(posedge clock_i) master_clear_pin_i <= 1;
      @(posedge clock_i) master_clear_pin_i <= 0;
      #1;
      chk({device_reset_o, powerdown_flag_o, timeout_flag_o, asleep_o}, 4'he);
   endtask : s_pin_reset
   task automatic final_report;
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report
   initial begin
      repeat (3) @(posedge clock_i);
      rst_i <= 0;
      step(1);
      chk({powerdown_flag_o, timeout_flag_o}, 2'h3);
      s_noop();
      s_sources();
      s_irq();
      s_watchdog();
      s_pin_reset();
      final_report();
   end
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         final_report();
      end
   end
endmodule : sleep_wakeup_controller_tb

// ---- sleep_wakeup_pkg.sv ----
/*
 * Constants and state type for the sleep and wake-up controller.
 * Assumes a single 200 MHz clock and a synchronous active-high reset.
 */
package sleep_wakeup_pkg;

   localparam int unsigned CLOCK_MHZ = 200;
   localparam int unsigned STATUS_PD_BIT = 3;
   localparam int unsigned STATUS_TO_BIT = 4;
   localparam logic POWERDOWN_FLAG_RESET = 1'b1;
   localparam logic TIMEOUT_FLAG_RESET = 1'b1;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   localparam int unsigned OSC_START_PERIODS = 1024;
   localparam int unsigned OSC_DIV_DEFAULT = 4;
   localparam int unsigned DUMMY_CYCLES = 2;
   localparam int unsigned NUM_PERIPH = 9;

   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_SLEEP = 3'b001,
      ST_OSC_WAIT = 3'b011,
      ST_PREFETCH = 3'b010,
      ST_DUMMY = 3'b110
   } wake_state_t;

endpackage : sleep_wakeup_pkg
